/* File: hdl/rfc_frame_regs.v */
// framing configuration and status registers with their framing helpers
`include "rfc_consts.vh"

module rfc_frame_regs (
    input  wire       CLK,               // system clock, 10 MHz
    input  wire       SYS_RST,           // synchronous reset, active high
    input  wire [7:0] ADDR,              // register address
    input  wire [7:0] WDATA,             // write data
    input  wire       WR,                // write strobe
    input  wire       RD,                // read strobe
    output reg  [7:0] RDATA,             // read data, cycle after RD
    input  wire       TX_DONE,           // pulse: end of sent data
    input  wire       RX_DONE,           // pulse: end of received data stream
    output reg        TX_GAP_BUSY,       // transmit must wait while high
    input  wire [7:0] TX_BYTE,           // byte being sent
    input  wire       TX_BYTE_VALID,     // pulse: TX_BYTE is sent
    output reg        TX_PARITY,         // parity bit to append
    output reg        TX_PARITY_VALID,   // pulse: TX_PARITY applies
    output reg        TX_BEGIN_ON,       // a begin symbol is sent
    output reg  [1:0] TX_BEGIN_PATTERN,  // 0..2: pattern zero, one, two
    output reg        TX_END_ON,         // an end symbol is sent
    output reg  [1:0] TX_END_PATTERN,    // 0..2: pattern zero, one, two
    input  wire [7:0] RX_BYTE,           // received byte
    input  wire       RX_BYTE_PARITY,    // received parity bit
    input  wire       RX_BYTE_VALID,     // pulse: RX_BYTE received
    input  wire       RX_BYTE_PARTIAL,   // RX_BYTE is an incomplete last byte
    input  wire       RX_CRC_ON,         // receive CRC checking enabled
    input  wire [7:0] RX_ERROR,          // current error register contents
    output reg  [7:0] FIFO_WDATA,        // byte to the receive FIFO
    output reg        FIFO_WR,           // pulse: write FIFO_WDATA
    output reg        RX_PARITY_ERR,     // pulse: received parity wrong
    output reg        RX_PARITY_CHECK,   // receive parity checking active
    output reg        RX_TERMINATE,      // pulse: receiver stops after frame
    output reg        RX_EOF_TYPE_B,     // Type B end-of-frame expected
    output reg        RX_EOF_CHECK,      // end-of-frame is checked
    output reg  [2:0] RX_RATE,           // receive rate code
    output reg        RX_RATE_VALID,     // rate code not reserved
    input  wire       SOF_PIN,           // asynchronous frame-start detect
    input  wire       SUBC_PIN,          // asynchronous subcarrier detect
    output reg        RX_FRAME_START_IRQ // pulse: frame-start interrupt
);
    // programmable registers
    reg  [7:0] tx_gap_control_reg;
    reg  [7:0] tx_gap_low_reg;
    reg  [7:0] frame_config_reg;
    reg  [7:0] rx_frame_start_detect_reg;
    reg  [7:0] rx_control_reg;
    reg  [7:0] rx_end_symbol_reg;

    // sticky flags and edge history
    reg        sof_seen_reg;
    reg        subc_seen_reg;
    reg        sof_prev_reg;
    reg        subc_prev_reg;

    // pending error byte for continuous receive
    reg        err_pend_reg;
    reg  [7:0] err_copy_reg;

    reg  [7:0] rd_next;
    reg  [31:0] half_bit_full;
    wire [7:0] unit_cyc;
    localparam [31:0] carrier_full = `RFC_CARRIER_UNIT_CYC;

    wire       sof_now;
    wire       subcarrier_now;
    wire       sof_event;
    wire       subc_event;
    wire       gap_busy;
    wire       gap_start;
    wire [10:0] tx_gap_time;
    wire       gap_origin_select;
    wire       gap_unit_select;
    wire [1:0] end_symbol_select;
    wire [1:0] begin_symbol_select;
    wire       rx_partial_byte_keep;
    wire       rx_continuous;
    wire       rx_end_format;
    wire       byte_store;
    wire       wr_sof;

    // pins from the analog receiver arrive unsynchronised
    rfc_sync3 u_sync_sof (
        .clk  (CLK),
        .rst  (SYS_RST),
        .din  (SOF_PIN),
        .dout (sof_now)
    );

    rfc_sync3 u_sync_subc (
        .clk  (CLK),
        .rst  (SYS_RST),
        .din  (SUBC_PIN),
        .dout (subcarrier_now)
    );

    assign sof_event  = sof_now & ~sof_prev_reg;
    assign subc_event = subcarrier_now & ~subc_prev_reg;

    // field views
    assign gap_origin_select    = tx_gap_control_reg[`RFC_BIT_GAP_ORIGIN];
    assign gap_unit_select      = tx_gap_control_reg[`RFC_BIT_GAP_UNIT];
    assign tx_gap_time          = {tx_gap_control_reg[`RFC_GAP_HI_MSB:`RFC_GAP_HI_LSB],
                                   tx_gap_low_reg};
    assign end_symbol_select    = frame_config_reg[`RFC_END_SEL_MSB:`RFC_END_SEL_LSB];
    assign begin_symbol_select  = frame_config_reg[`RFC_BEG_SEL_MSB:`RFC_BEG_SEL_LSB];
    assign rx_partial_byte_keep = rx_control_reg[`RFC_BIT_PART_KEEP];
    assign rx_continuous        = rx_control_reg[`RFC_BIT_CONT];
    assign rx_end_format        = rx_control_reg[`RFC_BIT_END_FMT];
    assign wr_sof               = WR && (ADDR == `RFC_OFS_SOF_DET);

    // gap origin: end of sent data, or end of received data
    assign gap_start = gap_origin_select ? RX_DONE : TX_DONE;

    // half a bit period per rate code, rounded up to whole cycles
    always @* begin
        case (rx_control_reg[`RFC_RATE_MSB:0])
            3'h2:    half_bit_full = `RFC_HALF_BIT_CYC(`RFC_RATE_26);
            3'h3:    half_bit_full = `RFC_HALF_BIT_CYC(`RFC_RATE_52);
            3'h4:    half_bit_full = `RFC_HALF_BIT_CYC(`RFC_RATE_106);
            3'h5:    half_bit_full = `RFC_HALF_BIT_CYC(`RFC_RATE_212);
            3'h6:    half_bit_full = `RFC_HALF_BIT_CYC(`RFC_RATE_424);
            3'h7:    half_bit_full = `RFC_HALF_BIT_CYC(`RFC_RATE_847);
            // reserved rate: fall back to the carrier unit
            default: half_bit_full = `RFC_CARRIER_UNIT_CYC;
        endcase
    end

    // all unit counts fit a byte; the low byte is taken on purpose
    assign unit_cyc = gap_unit_select ? half_bit_full[7:0] : carrier_full[7:0];


    rfc_gap_timer u_gap (
        .clk      (CLK),
        .rst      (SYS_RST),
        .start    (gap_start),
        .gap      (tx_gap_time),
        .unit_cyc (unit_cyc),
        .busy     (gap_busy)
    );

    // incomplete last byte is dropped under CRC unless kept
    assign byte_store = RX_BYTE_VALID &&
                        !(RX_BYTE_PARTIAL && RX_CRC_ON && !rx_partial_byte_keep);

    // register writes
    always @(posedge CLK) begin
        if (SYS_RST) begin
            tx_gap_control_reg <= `RFC_RST_GAP_CTRL;
            tx_gap_low_reg     <= `RFC_RST_GAP_LOW;
            frame_config_reg   <= `RFC_RST_FRAME_CFG;
            rx_frame_start_detect_reg <= `RFC_RST_SOF_DET;
            rx_control_reg     <= `RFC_RST_RX_CTRL;
            rx_end_symbol_reg  <= `RFC_RST_END_SYM;
        end else if (WR) begin
            case (ADDR)
                `RFC_OFS_GAP_CTRL:  tx_gap_control_reg <= WDATA;
                `RFC_OFS_GAP_LOW:   tx_gap_low_reg     <= WDATA;
                `RFC_OFS_FRAME_CFG: frame_config_reg   <= WDATA & `RFC_MASK_FRAME_CFG;
                `RFC_OFS_SOF_DET:   rx_frame_start_detect_reg <= WDATA & `RFC_MASK_SOF_DET;
                `RFC_OFS_RX_CTRL:   rx_control_reg     <= WDATA;
                `RFC_OFS_END_SYM:   rx_end_symbol_reg  <= WDATA & `RFC_MASK_END_SYM;
                default: ;
            endcase
        end
    end

    // sticky detection flags: set beats a software clear in the same cycle
    always @(posedge CLK) begin
        if (SYS_RST) begin
            sof_seen_reg  <= 1'b0;
            subc_seen_reg <= 1'b0;
            sof_prev_reg  <= 1'b0;
            subc_prev_reg <= 1'b0;
        end else begin
            sof_prev_reg  <= sof_now;
            subc_prev_reg <= subcarrier_now;
            if (sof_event) begin
                sof_seen_reg <= 1'b1;
            end else if (wr_sof && !WDATA[`RFC_BIT_SOF_SEEN]) begin
                sof_seen_reg <= 1'b0;
            end
            if (subc_event) begin
                subc_seen_reg <= 1'b1;
            end else if (wr_sof && !WDATA[`RFC_BIT_SUBC_SEEN]) begin
                subc_seen_reg <= 1'b0;
            end
        end
    end

    // read mux; masked bits read zero, unused bits of gap and rx control read back as written
    always @* begin
        case (ADDR)
            `RFC_OFS_GAP_CTRL:  rd_next = tx_gap_control_reg;
            `RFC_OFS_GAP_LOW:   rd_next = tx_gap_low_reg;
            `RFC_OFS_FRAME_CFG: rd_next = frame_config_reg;
            `RFC_OFS_SOF_DET: begin
                rd_next = rx_frame_start_detect_reg & `RFC_MASK_SOF_DET;
                rd_next[`RFC_BIT_SOF_SEEN]  = sof_seen_reg;
                rd_next[`RFC_BIT_SUBC_SEEN] = subc_seen_reg;
                rd_next[`RFC_BIT_SUBC_NOW]  = subcarrier_now;
            end
            `RFC_OFS_RX_CTRL:   rd_next = rx_control_reg;
            `RFC_OFS_END_SYM:   rd_next = rx_end_symbol_reg;
            default:            rd_next = 8'h00;
        endcase
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            RDATA <= 8'h00;
        end else begin
            // read data live for one cycle only
            RDATA <= RD ? rd_next : 8'h00;
        end
    end

    // transmit side: gap, parity and symbol selection
    always @(posedge CLK) begin
        if (SYS_RST) begin
            TX_GAP_BUSY      <= 1'b0;
            TX_PARITY        <= 1'b0;
            TX_PARITY_VALID  <= 1'b0;
            TX_BEGIN_ON      <= 1'b0;
            TX_BEGIN_PATTERN <= 2'h0;
            TX_END_ON        <= 1'b0;
            TX_END_PATTERN   <= 2'h0;
        end else begin
            TX_GAP_BUSY     <= gap_busy;
            // odd parity over each sent byte
            TX_PARITY       <= ~(^TX_BYTE);
            TX_PARITY_VALID <= TX_BYTE_VALID && frame_config_reg[`RFC_BIT_TX_PAR];
            TX_BEGIN_ON     <= (begin_symbol_select != 2'h0);
            TX_BEGIN_PATTERN <= (begin_symbol_select == 2'h0) ? 2'h0 : begin_symbol_select - 2'h1;

            TX_END_ON       <= (end_symbol_select != 2'h0);
            TX_END_PATTERN  <= (end_symbol_select == 2'h0) ? 2'h0 : end_symbol_select - 2'h1;
        end
    end

    // receive side: FIFO writes, parity check, end-of-frame options
    always @(posedge CLK) begin
        if (SYS_RST) begin
            FIFO_WDATA      <= 8'h00;
            FIFO_WR         <= 1'b0;
            RX_PARITY_ERR   <= 1'b0;
            RX_PARITY_CHECK <= 1'b0;
            RX_TERMINATE    <= 1'b0;
            RX_EOF_TYPE_B   <= 1'b0;
            RX_EOF_CHECK    <= 1'b0;
            RX_RATE         <= 3'h0;
            RX_RATE_VALID   <= 1'b0;
            err_pend_reg    <= 1'b0;
            err_copy_reg    <= 8'h00;
        end else begin

            RX_PARITY_CHECK <= frame_config_reg[`RFC_BIT_RX_PAR];
            // odd parity: nine bits must xor to one
            RX_PARITY_ERR   <= RX_BYTE_VALID && frame_config_reg[`RFC_BIT_RX_PAR] &&
                               !(^{RX_BYTE, RX_BYTE_PARITY});

            RX_TERMINATE    <= RX_DONE && !rx_continuous;
            RX_EOF_TYPE_B   <= rx_end_format;
            RX_EOF_CHECK    <= rx_end_format || (rx_end_symbol_reg[1:0] != 2'h0);
            RX_RATE         <= rx_control_reg[`RFC_RATE_MSB:0];
            RX_RATE_VALID   <= (rx_control_reg[`RFC_RATE_MSB:0] >= 3'h2);

            FIFO_WR         <= 1'b0;

            if (RX_DONE && rx_continuous) begin
                // error byte is snapped at stream end, written after data
                err_pend_reg <= 1'b1;
                err_copy_reg <= RX_ERROR;
            end

            if (byte_store) begin
                FIFO_WDATA <= RX_BYTE;
                FIFO_WR    <= 1'b1;
            end else if (err_pend_reg) begin
                FIFO_WDATA   <= err_copy_reg;
                FIFO_WR      <= 1'b1;
                if (!(RX_DONE && rx_continuous)) begin
                    err_pend_reg <= 1'b0;
                end
            end
        end
    end

    // either enabled detection event raises the one interrupt
    always @(posedge CLK) begin
        if (SYS_RST) begin
            RX_FRAME_START_IRQ <= 1'b0;
        end else begin
            RX_FRAME_START_IRQ <=
                (sof_event && rx_frame_start_detect_reg[`RFC_BIT_SOF_IRQ]) ||
                (subc_event && rx_frame_start_detect_reg[`RFC_BIT_SUBC_IRQ]);
        end
    end
endmodule // rfc_frame_regs

/* File: hdl/rfc_consts.vh */
// constants of the framing configuration register bank
`ifndef RFC_CONSTS_VH
`define RFC_CONSTS_VH

`define RFC_OFS_GAP_CTRL   8'h31
`define RFC_OFS_GAP_LOW    8'h32
`define RFC_OFS_FRAME_CFG  8'h33
`define RFC_OFS_SOF_DET    8'h34
`define RFC_OFS_RX_CTRL    8'h35
`define RFC_OFS_END_SYM    8'h40

`define RFC_RST_GAP_CTRL   8'hc0
`define RFC_RST_GAP_LOW    8'h00
`define RFC_RST_FRAME_CFG  8'h00
`define RFC_RST_SOF_DET    8'h00
`define RFC_RST_RX_CTRL    8'h00
`define RFC_RST_END_SYM    8'h00

`define RFC_MASK_FRAME_CFG 8'hcf
`define RFC_MASK_SOF_DET   8'h37
`define RFC_MASK_END_SYM   8'h03

`define RFC_BIT_GAP_ORIGIN 7
`define RFC_BIT_GAP_UNIT   6
`define RFC_GAP_HI_MSB     5
`define RFC_GAP_HI_LSB     3
`define RFC_BIT_TX_PAR     7
`define RFC_BIT_RX_PAR     6
`define RFC_END_SEL_MSB    3
`define RFC_END_SEL_LSB    2
`define RFC_BEG_SEL_MSB    1
`define RFC_BEG_SEL_LSB    0
`define RFC_BIT_SOF_IRQ    5
`define RFC_BIT_SOF_SEEN   4
`define RFC_BIT_SUBC_IRQ   2
`define RFC_BIT_SUBC_SEEN  1
`define RFC_BIT_SUBC_NOW   0
`define RFC_BIT_PART_KEEP  7
`define RFC_BIT_CONT       6
`define RFC_BIT_END_FMT    5
`define RFC_RATE_MSB       2

`define RFC_CLK_KHZ        10000
`define RFC_CARRIER_KHZ    13560
`define RFC_CARRIER_PER_UNIT 16
`define RFC_CARRIER_UNIT_CYC ((`RFC_CARRIER_PER_UNIT * `RFC_CLK_KHZ + `RFC_CARRIER_KHZ - 1) / `RFC_CARRIER_KHZ)
`define RFC_HALF_BIT_CYC(kbd) ((`RFC_CLK_KHZ + 2 * (kbd) - 1) / (2 * (kbd)))
`define RFC_RATE_26        26
`define RFC_RATE_52        52
`define RFC_RATE_106       106
`define RFC_RATE_212       212
`define RFC_RATE_424       424
`define RFC_RATE_847       847

`endif

/* File: hdl/rfc_sync3.v */
// three-stage synchroniser for one asynchronous level
module rfc_sync3 (
    input  wire clk,     // system clock
    input  wire rst,     // synchronous reset, active high
    input  wire din,     // asynchronous level
    output reg  dout     // filtered level
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    always @(posedge clk) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            dout   <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // only take a value once stages two and three agree
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end
endmodule // rfc_sync3

/* File: hdl/rfc_gap_timer.v */
// minimum-gap timer: counts gap units of a programmable cycle length
module rfc_gap_timer (
    input  wire        clk,       // system clock
    input  wire        rst,       // synchronous reset, active high
    input  wire        start,     // one-cycle start pulse
    input  wire [10:0] gap,       // gap length in units
    input  wire [7:0]  unit_cyc,  // clock cycles per unit
    output reg         busy       // high while the gap runs
);
    reg [10:0] unit_left_reg;
    reg [7:0]  pre_reg;

    always @(posedge clk) begin
        if (rst) begin
            busy          <= 1'b0;
            unit_left_reg <= 11'h000;
            pre_reg       <= 8'h00;
        end else if (start) begin
            // a new start restarts the gap; a zero gap never blocks
            busy          <= (gap != 11'h000);
            unit_left_reg <= gap;
            pre_reg       <= unit_cyc - 8'h01;
        end else if (busy) begin
            if (pre_reg != 8'h00) begin
                pre_reg <= pre_reg - 8'h01;
            end else begin
                pre_reg       <= unit_cyc - 8'h01;
                unit_left_reg <= unit_left_reg - 11'h001;
                if (unit_left_reg == 11'h001) begin
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule // rfc_gap_timer

/* File: sim/rfc_frame_regs_props.sv */
// port assertions for the framing register bank
module rfc_frame_regs_props (
    input logic       CLK,              // clock
    input logic       SYS_RST,          // reset
    input logic       RD,               // read strobe
    input logic [7:0] RDATA,            // read data
    input logic       TX_DONE,          // sent end
    input logic       RX_DONE,          // received end
    input logic       TX_GAP_BUSY,      // gap runs
    input logic [7:0] TX_BYTE,          // sent byte
    input logic       TX_BYTE_VALID,    // sent strobe
    input logic       TX_PARITY,        // parity bit
    input logic       TX_PARITY_VALID,  // parity strobe
    input logic       TX_BEGIN_ON,      // begin on
    input logic [1:0] TX_BEGIN_PATTERN, // begin pattern
    input logic [7:0] RX_BYTE,          // rx byte
    input logic       RX_BYTE_VALID,    // rx strobe
    input logic       RX_BYTE_PARTIAL,  // partial
    input logic       RX_CRC_ON,        // crc on
    input logic [7:0] FIFO_WDATA,       // fifo byte
    input logic       FIFO_WR,          // fifo strobe
    input logic       RX_TERMINATE,     // rx stop
    input logic       RX_EOF_TYPE_B,    // type b end
    input logic       RX_EOF_CHECK,     // end checked
    input logic [2:0] RX_RATE,          // rate code
    input logic       RX_RATE_VALID     // rate usable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read slot");
    chk_par_value: assert property (TX_PARITY_VALID |-> TX_PARITY == ~^$past(TX_BYTE))
        else $error("tx parity not odd");
    chk_par_cause: assert property (TX_PARITY_VALID |-> $past(TX_BYTE_VALID))
        else $error("tx parity without byte");
    chk_fifo_store: assert property ($past(RX_BYTE_VALID && !(RX_BYTE_PARTIAL && RX_CRC_ON))
        |-> FIFO_WR && FIFO_WDATA == $past(RX_BYTE)) else $error("rx byte not stored");
    chk_term_cause: assert property (RX_TERMINATE |-> $past(RX_DONE))
        else $error("terminate without end");
    chk_rate_flag: assert property (RX_RATE_VALID == (RX_RATE >= 3'h2))
        else $error("rate flag wrong");
    chk_begin_code: assert property (TX_BEGIN_PATTERN != 2'h3 && (TX_BEGIN_ON || TX_BEGIN_PATTERN == 2'h0))
        else $error("begin pattern wrong");
    chk_gap_start: assert property ($rose(TX_GAP_BUSY) |-> $past(TX_DONE || RX_DONE, 2))
        else $error("gap without start");
    chk_eof_check: assert property (RX_EOF_TYPE_B |-> RX_EOF_CHECK)
        else $error("type b end unchecked");
endmodule // rfc_frame_regs_props

bind rfc_frame_regs rfc_frame_regs_props u_props (
    .CLK(CLK), .SYS_RST(SYS_RST), .RD(RD), .RDATA(RDATA), .TX_DONE(TX_DONE), .RX_DONE(RX_DONE),
    .TX_GAP_BUSY(TX_GAP_BUSY), .TX_BYTE(TX_BYTE), .TX_BYTE_VALID(TX_BYTE_VALID), .TX_PARITY(TX_PARITY),
    .TX_PARITY_VALID(TX_PARITY_VALID), .TX_BEGIN_ON(TX_BEGIN_ON), .TX_BEGIN_PATTERN(TX_BEGIN_PATTERN),
    .RX_BYTE(RX_BYTE), .RX_BYTE_VALID(RX_BYTE_VALID), .RX_BYTE_PARTIAL(RX_BYTE_PARTIAL), .RX_CRC_ON(RX_CRC_ON),
    .FIFO_WDATA(FIFO_WDATA), .FIFO_WR(FIFO_WR), .RX_TERMINATE(RX_TERMINATE), .RX_EOF_TYPE_B(RX_EOF_TYPE_B),
    .RX_EOF_CHECK(RX_EOF_CHECK), .RX_RATE(RX_RATE), .RX_RATE_VALID(RX_RATE_VALID)
);

/* File: sim/rfc_rf_model.sv */
// radio-side stand-in: frame ends, byte strobes, detector pins
module rfc_rf_model (
    input  logic       clk,        // clock
    output logic       tx_done,    // sent end
    output logic       rx_done,    // received end
    output logic [7:0] tx_byte,    // sent byte
    output logic       tx_valid,   // sent strobe
    output logic [7:0] rx_byte,    // rx byte
    output logic       rx_parity,  // rx parity bit
    output logic       rx_valid,   // rx strobe
    output logic       rx_partial, // partial byte
    output logic       rx_crc_on,  // crc on
    output logic [7:0] rx_error,   // error copy
    output logic       sof_pin,    // frame start
    output logic       subc_pin    // subcarrier
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {tx_done, rx_done, tx_valid, rx_valid, rx_partial, rx_crc_on, sof_pin, subc_pin} = '0;
        {tx_byte, rx_byte, rx_parity, rx_error} = '0;
    end
    // data inverted after strobe: stale never looks fresh
    task send_tx(input logic [7:0] b);
        @(posedge clk);
        tx_byte <= b;
        tx_valid <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b0;
        tx_byte <= ~b;
    endtask
    // partial implies crc on
    task send_rx(input logic [7:0] b, input logic p, part);
        @(posedge clk);
        rx_byte <= b;
        rx_parity <= p;
        rx_partial <= part;
        rx_crc_on <= part;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
    task end_frame(input logic rx_side, logic [7:0] err);
        @(posedge clk);
        rx_error <= err;
        rx_done <= rx_side;
        tx_done <= !rx_side;
        @(posedge clk);
        rx_done <= 1'b0;
        tx_done <= 1'b0;
    endtask
    task set_pins(input logic sof, subc);
        @(posedge clk);
        sof_pin <= sof;
        subc_pin <= subc;
        repeat (8) @(posedge clk);
    endtask
endmodule // rfc_rf_model

/* File: sim/tb_top.sv */
// self-checking bench for the framing register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, sys_rst, wr, rd, tx_done, rx_done, tx_valid, rx_par, rx_valid, rx_part, rx_crc, sof, subc;
    logic [7:0] addr, wdata, rdata, tx_byte, rx_byte, rx_err, fifo_data;
    logic       busy, tx_par, tx_par_v, beg_on, end_on, fifo_wr, perr, pchk, term, eof_b, eof_chk, rate_v, irq;
    logic [1:0] beg_pat, end_pat;
    logic [2:0] rate;
    int         n_fail = 0, check_count = 0, n_irq = 0, n_perr = 0, n_term = 0;
    // carrier unit in whole clocks
    localparam int CARRIER_CYC = 12;

    rfc_frame_regs dut (
        .CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .TX_DONE(tx_done), .RX_DONE(rx_done), .TX_GAP_BUSY(busy), .TX_BYTE(tx_byte), .TX_BYTE_VALID(tx_valid),
        .TX_PARITY(tx_par), .TX_PARITY_VALID(tx_par_v), .TX_BEGIN_ON(beg_on), .TX_BEGIN_PATTERN(beg_pat),
        .TX_END_ON(end_on), .TX_END_PATTERN(end_pat), .RX_BYTE(rx_byte), .RX_BYTE_PARITY(rx_par),
        .RX_BYTE_VALID(rx_valid), .RX_BYTE_PARTIAL(rx_part), .RX_CRC_ON(rx_crc), .RX_ERROR(rx_err),
        .FIFO_WDATA(fifo_data), .FIFO_WR(fifo_wr), .RX_PARITY_ERR(perr), .RX_PARITY_CHECK(pchk),
        .RX_TERMINATE(term), .RX_EOF_TYPE_B(eof_b), .RX_EOF_CHECK(eof_chk), .RX_RATE(rate),
        .RX_RATE_VALID(rate_v), .SOF_PIN(sof), .SUBC_PIN(subc), .RX_FRAME_START_IRQ(irq)
    );
    rfc_rf_model rf (
        .clk(clk), .tx_done(tx_done), .rx_done(rx_done), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .rx_byte(rx_byte), .rx_parity(rx_par), .rx_valid(rx_valid), .rx_partial(rx_part),
        .rx_crc_on(rx_crc), .rx_error(rx_err), .sof_pin(sof), .subc_pin(subc)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // pulse counters
    always @(posedge clk) begin
        n_irq <= n_irq + (irq === 1'b1);
        n_perr <= n_perr + (perr === 1'b1);
        n_term <= n_term + (term === 1'b1);
    end

    task cmp(input string what, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr_reg(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp("rdata", exp, rdata);
    endtask
    task settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task end_sim();
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task t_reset_vals();
        rd_reg(8'h31, 8'hc0);
        rd_reg(8'h32, 8'h00);
        rd_reg(8'h34, 8'h00);
        rd_reg(8'h36, 8'h00);
    endtask
    task automatic t_access();
        logic [7:0] a [7] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h40};
        logic [7:0] e [7] = '{8'hff, 8'hff, 8'hcf, 8'h24, 8'hff, 8'h00, 8'h03};
        for (int i = 0; i < 7; i++) begin
            wr_reg(a[i], 8'hff);
            rd_reg(a[i], e[i]);
            wr_reg(a[i], 8'h00);
        end
    endtask
    task t_symbols();
        logic [1:0] b;
        for (int c = 0; c < 4; c++) begin
            b = 2'(3 - c);
            wr_reg(8'h33, {4'h0, c[1:0], b});
            settle();
            cmp("end_on", c != 0, end_on);
            cmp("end_pat", c == 0 ? 2'h0 : c[1:0] - 2'h1, end_pat);
            cmp("begin_on", b != 0, beg_on);
            cmp("begin_pat", b == 0 ? 2'h0 : b - 2'h1, beg_pat);
        end
    endtask
    task t_tx_parity();
        wr_reg(8'h33, 8'h80);
        rf.send_tx(8'ha5);
        #1 cmp("parity_valid", 1'b1, tx_par_v);
        cmp("parity_bit", 1'b1, tx_par);
        wr_reg(8'h33, 8'h00);
        rf.send_tx(8'h07);
        #1 cmp("parity_valid", 1'b0, tx_par_v);
    endtask
    task t_rx();
        int k;
        wr_reg(8'h33, 8'h40);
        settle();
        cmp("par_check", 1'b1, pchk);
        k = n_perr;
        rf.send_rx(8'h3c, 1'b1, 1'b0);
        #1 cmp("fifo_data", 8'h3c, fifo_data);
        rf.send_rx(8'h3c, 1'b0, 1'b0);
        settle();
        cmp("par_errors", k + 1, n_perr);
        rf.send_rx(8'h15, 1'b0, 1'b1);
        #1 cmp("fifo_wr", 1'b0, fifo_wr);
        wr_reg(8'h35, 8'h80);
        rf.send_rx(8'h16, 1'b0, 1'b1);
        #1 cmp("fifo_wr", 1'b1, fifo_wr);
        wr_reg(8'h35, 8'h40);
        k = n_term;
        rf.end_frame(1'b1, 8'h5a);
        @(posedge clk) #1;
        cmp("error_wr", 1'b1, fifo_wr);
        cmp("error_byte", 8'h5a, fifo_data);
        settle();
        cmp("stops", k, n_term);
        wr_reg(8'h35, 8'h00);
        rf.end_frame(1'b1, 8'h11);
        settle();
        cmp("stops", k + 1, n_term);
    endtask
    task t_eof_rate();
        wr_reg(8'h35, 8'h20);
        settle();
        cmp("eof_type_b", 1'b1, eof_b);
        wr_reg(8'h35, 8'h00);
        settle();
        cmp("eof_check", 1'b0, eof_chk);
        wr_reg(8'h40, 8'h02);
        settle();
        cmp("eof_check", 1'b1, eof_chk);
        for (int r = 0; r < 8; r++) begin
            wr_reg(8'h35, 8'(r));
            settle();
            cmp("rate", r[2:0], rate);
            cmp("rate_ok", r >= 2, rate_v);
        end
    endtask
    task t_detect();
        int k;
        k = n_irq;
        wr_reg(8'h34, 8'h24);
        rf.set_pins(1'b0, 1'b1);
        rd_reg(8'h34, 8'h27);
        cmp("irqs", k + 1, n_irq);
        rf.set_pins(1'b0, 1'b0);
        rd_reg(8'h34, 8'h26);
        wr_reg(8'h34, 8'h24);
        rd_reg(8'h34, 8'h24);
        wr_reg(8'h34, 8'h04);
        rf.set_pins(1'b1, 1'b0);
        wr_reg(8'h34, 8'h14);
        rd_reg(8'h34, 8'h14);
        cmp("irqs", k + 1, n_irq);
        rf.set_pins(1'b0, 1'b0);
        wr_reg(8'h34, 8'h20);
        rf.set_pins(1'b1, 1'b0);
        rd_reg(8'h34, 8'h30);
        cmp("irqs", k + 2, n_irq);
        rf.set_pins(1'b0, 1'b0);
    endtask
    task gap_run(input logic rx_side, int exp);
        int n;
        n = 0;
        rf.end_frame(rx_side, 8'h00);
        repeat (exp + 8) begin
            @(posedge clk);
            #1 n += (busy === 1'b1);
        end
        cmp("gap_cycles", exp, n);
    endtask
    task t_gap();
        wr_reg(8'h31, 8'h00);
        wr_reg(8'h32, 8'h03);
        gap_run(1'b0, 3 * CARRIER_CYC);
        wr_reg(8'h31, 8'h08);
        gap_run(1'b0, 259 * CARRIER_CYC);
        wr_reg(8'h31, 8'h80);
        wr_reg(8'h32, 8'h02);
        gap_run(1'b0, 0);
        gap_run(1'b1, 2 * CARRIER_CYC);
        wr_reg(8'h35, 8'h07);
        wr_reg(8'h31, 8'hc0);
        // half a bit at 847 kBd is 6 clocks
        gap_run(1'b1, 2 * 6);
    endtask

    initial begin
        {addr, wdata, wr, rd} = '0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset_vals();
        t_access();
        t_symbols();
        t_tx_parity();
        t_rx();
        t_eof_rate();
        t_detect();
        t_gap();
        end_sim();
    end
    initial begin
        #3000000;
        n_fail++;
        end_sim();
    end
endmodule // tb_top
